// >>> hw/scan_tap_pkg.sv
package scan_tap_pkg;

  // ==========================================================================
  // Scan path lengths
  localparam int unsigned IR_LEN = 3;
  localparam int unsigned BYP_LEN = 1;
  localparam int unsigned ID_LEN = 32;
  localparam int unsigned BSR_LEN = 107;

  // ==========================================================================
  // Instruction codes
  localparam logic [2:0] INSTR_EXTEST = 3'h0;
  localparam logic [2:0] INSTR_IDCODE = 3'h1;
  localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INSTR_SAMPLE = 3'h4;
  localparam logic [2:0] INSTR_BYPASS = 3'h7;
  localparam int unsigned INSTR_BIT_HIGH = 2; // Top bit of the code
  localparam int unsigned INSTR_BIT_LOW = 0; // Bottom bit of the code

  // ==========================================================================
  // Capture and reset values
  localparam logic [2:0] IR_CAPTURE_VAL = 3'h1; // Fixed 01 pattern in the low bits
  localparam logic [2:0] IR_RESET_VAL = INSTR_IDCODE;
  localparam logic BYP_CAPTURE_VAL = 1'b0;

  // ==========================================================================
  // Identification field positions
  localparam int unsigned ID_REV_LSB = 29;
  localparam int unsigned ID_CFG_LSB = 12;
  localparam int unsigned ID_MFR_LSB = 1;
  localparam int unsigned ID_START_BIT = 0;
  localparam int unsigned CFG_DENS_LSB = 12; // Three density bits 14:12
  localparam int unsigned CFG_WIDTH_LSB = 9; // Two width bits 10:9
  localparam int unsigned CFG_DONT_CARE = 7;
  localparam int unsigned CFG_QUAD = 5;
  localparam int unsigned CFG_BURST = 3;
  localparam int unsigned CFG_SEP_IO = 1;

  // Default identification contents; vendor and revision values are arbitrary
  localparam logic [2:0] ID_REV_DEFAULT = 3'h5;
  localparam logic [10:0] ID_MFR_DEFAULT = 11'h2a5;
  localparam logic [2:0] ID_DENS_DEFAULT = 3'h1;
  localparam logic [1:0] ID_WIDTH_DEFAULT = 2'h3;

  // ==========================================================================
  // Boundary cell without a pad (cell 48, zero based index 47)
  localparam int unsigned BSR_INTERNAL_IDX = 47;

  // ==========================================================================
  // Test controller states
  typedef enum logic [3:0] {
    ST_RESET = 4'b0000,
    ST_IDLE = 4'b0001,
    ST_SEL_DR = 4'b0010,
    ST_CAP_DR = 4'b0011,
    ST_SHIFT_DR = 4'b0100,
    ST_EXIT1_DR = 4'b0101,
    ST_PAUSE_DR = 4'b0110,
    ST_EXIT2_DR = 4'b0111,
    ST_UPD_DR = 4'b1000,
    ST_SEL_IR = 4'b1001,
    ST_CAP_IR = 4'b1010,
    ST_SHIFT_IR = 4'b1011,
    ST_EXIT1_IR = 4'b1100,
    ST_PAUSE_IR = 4'b1101,
    ST_EXIT2_IR = 4'b1110,
    ST_UPD_IR = 4'b1111
  } tap_state_e;

endpackage : scan_tap_pkg

// >>> hw/sync_stage.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Two flop synchroniser with asynchronous preset value
module sync_stage #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk, // Destination clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [WIDTH-1:0] d, // Signal from another domain
  output logic [WIDTH-1:0] q // Synchronised copy
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  // First stage feeds only the second
  always_comb begin
    st_next.meta = d;
    st_next.held = st_reg.meta;
  end

  // Both stages reset to the same constant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= {RESET_VAL, RESET_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.held;

endmodule : sync_stage

`default_nettype wire

// >>> hw/scan_tap.sv
// Behaviour
// R1: A sixteen state test controller resets itself at power up and needs no test reset pin.
// R2: Scan logic never shifts out or drives memory contents, only what sits at the pads.
// R3: In scan test modes the boundary cells observe the package pads.
// R4: Code 000 external test, 001 identity, 010 sample with float, 100 sample, 111 bypass.
// R5: External test floats the data outputs and captures all inputs.
// R6: Sample with float puts the data outputs in high impedance and captures every input.
// R7: Plain sample captures the pads without floating the data outputs.
// R8: Identification shifts the test input into its first stage behind the identity value.
// R9: Loading bypass clears the bypass bit, which then holds the last bit shifted in.
// R10: The tester never loads the three reserved codes.
// R11: Path lengths are 3, 1, 32 and 107 bits.
// R12: Identity holds revision 31:29, configuration 28:12, maker 11:1 and a one in bit 0.
// R13: The configuration field holds density, width, rate, burst and I/O sub-fields plus a spare.
// R14: The boundary chain has 107 cells in fixed order, cell 48 internal, open balls don't care.
// R15: States move on rising tck edges; tdo moves on falling edges and is driven only in shifts.
`timescale 1ns/1ps
`default_nettype none

module scan_tap #(
  parameter logic [2:0] ID_REVISION = scan_tap_pkg::ID_REV_DEFAULT,
  parameter logic [10:0] ID_MAKER = scan_tap_pkg::ID_MFR_DEFAULT,
  parameter logic [2:0] ID_DENSITY = scan_tap_pkg::ID_DENS_DEFAULT,
  parameter logic [1:0] ID_WIDTH_CODE = scan_tap_pkg::ID_WIDTH_DEFAULT,
  parameter logic ID_QUAD_RATE = 1'b1,
  parameter logic ID_BURST_FOUR = 1'b0,
  parameter logic ID_SEPARATE_IO = 1'b1
) (
  input wire logic core_clk, // Memory core clock
  input wire logic rst, // Power-up reset, asynchronous, active high
  input wire logic tck, // Test clock
  input wire logic tms, // Test mode select
  input wire logic tdi, // Test data in
  output logic tdo, // Test data out
  output logic tdo_oe, // Test data out enable, high while driving
  input wire logic [scan_tap_pkg::BSR_LEN-1:0] pad_in, // Pad levels, index k-1 is cell k
  output logic dq_hiz, // Data outputs floated, core clock domain
  output logic [2:0] active_instr // Current instruction, test clock domain
);

  // ==========================================================================
  // Identification value
  function automatic logic [16:0] part_cfg(input logic [2:0] dens, input logic [1:0] wid,
                                            input logic quad, input logic burst,
                                            input logic sep);
    logic [16:0] cfg;
    cfg = '0;
    cfg[scan_tap_pkg::CFG_DENS_LSB +: 3] = dens; // R13
    cfg[scan_tap_pkg::CFG_WIDTH_LSB +: 2] = wid; // R13
    cfg[scan_tap_pkg::CFG_DONT_CARE] = 1'b0;
    cfg[scan_tap_pkg::CFG_QUAD] = quad;
    cfg[scan_tap_pkg::CFG_BURST] = burst;
    cfg[scan_tap_pkg::CFG_SEP_IO] = sep;
    return cfg;
  endfunction : part_cfg

  function automatic logic [31:0] id_word(input logic [2:0] rev, input logic [16:0] cfg,
                                           input logic [10:0] mfr);
    logic [31:0] w;
    w = '0;
    w[scan_tap_pkg::ID_REV_LSB +: 3] = rev; // R12
    w[scan_tap_pkg::ID_CFG_LSB +: 17] = cfg; // R12
    w[scan_tap_pkg::ID_MFR_LSB +: 11] = mfr; // R12
    w[scan_tap_pkg::ID_START_BIT] = 1'b1; // R12
    return w;
  endfunction : id_word

  localparam logic [31:0] ID_VALUE = id_word(ID_REVISION,
      part_cfg(ID_DENSITY, ID_WIDTH_CODE, ID_QUAD_RATE, ID_BURST_FOUR, ID_SEPARATE_IO),
      ID_MAKER);

  // ==========================================================================
  // Controller transitions
  function automatic scan_tap_pkg::tap_state_e tap_step(input scan_tap_pkg::tap_state_e s,
                                                       input logic m);
    scan_tap_pkg::tap_state_e n;
    case (s)
      scan_tap_pkg::ST_RESET: n = m ? scan_tap_pkg::ST_RESET : scan_tap_pkg::ST_IDLE;
      scan_tap_pkg::ST_IDLE: n = m ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
      scan_tap_pkg::ST_SEL_DR: n = m ? scan_tap_pkg::ST_SEL_IR : scan_tap_pkg::ST_CAP_DR;
      scan_tap_pkg::ST_CAP_DR: n = m ? scan_tap_pkg::ST_EXIT1_DR : scan_tap_pkg::ST_SHIFT_DR;
      scan_tap_pkg::ST_SHIFT_DR: n = m ? scan_tap_pkg::ST_EXIT1_DR : scan_tap_pkg::ST_SHIFT_DR;
      scan_tap_pkg::ST_EXIT1_DR: n = m ? scan_tap_pkg::ST_UPD_DR : scan_tap_pkg::ST_PAUSE_DR;
      scan_tap_pkg::ST_PAUSE_DR: n = m ? scan_tap_pkg::ST_EXIT2_DR : scan_tap_pkg::ST_PAUSE_DR;
      scan_tap_pkg::ST_EXIT2_DR: n = m ? scan_tap_pkg::ST_UPD_DR : scan_tap_pkg::ST_SHIFT_DR;
      scan_tap_pkg::ST_UPD_DR: n = m ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
      scan_tap_pkg::ST_SEL_IR: n = m ? scan_tap_pkg::ST_RESET : scan_tap_pkg::ST_CAP_IR;
      scan_tap_pkg::ST_CAP_IR: n = m ? scan_tap_pkg::ST_EXIT1_IR : scan_tap_pkg::ST_SHIFT_IR;
      scan_tap_pkg::ST_SHIFT_IR: n = m ? scan_tap_pkg::ST_EXIT1_IR : scan_tap_pkg::ST_SHIFT_IR;
      scan_tap_pkg::ST_EXIT1_IR: n = m ? scan_tap_pkg::ST_UPD_IR : scan_tap_pkg::ST_PAUSE_IR;
      scan_tap_pkg::ST_PAUSE_IR: n = m ? scan_tap_pkg::ST_EXIT2_IR : scan_tap_pkg::ST_PAUSE_IR;
      scan_tap_pkg::ST_EXIT2_IR: n = m ? scan_tap_pkg::ST_UPD_IR : scan_tap_pkg::ST_SHIFT_IR;
      scan_tap_pkg::ST_UPD_IR: n = m ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
      default: n = scan_tap_pkg::ST_RESET;
    endcase
    return n;
  endfunction : tap_step

  // Instructions that route the boundary chain
  function automatic logic uses_chain(input logic [2:0] code);
    return (code == scan_tap_pkg::INSTR_EXTEST) || (code == scan_tap_pkg::INSTR_SAMPLE_Z) ||
           (code == scan_tap_pkg::INSTR_SAMPLE);
  endfunction : uses_chain

  // ==========================================================================
  // Reset and crossings
  logic tap_rst;
  logic [scan_tap_pkg::BSR_LEN-1:0] pad_sync;
  logic float_core;

  // Power-up reset lands on the test clock with synchronous release
  sync_stage #(.WIDTH(1), .RESET_VAL(1'b1)) u_tap_rst (
    .clk(tck),
    .rst(rst),
    .d(1'b0),
    .q(tap_rst)
  );

  // Pads are asynchronous to the test clock; only static levels are meaningful
  sync_stage #(.WIDTH(scan_tap_pkg::BSR_LEN), .RESET_VAL('0)) u_pad_sync (
    .clk(tck),
    .rst(tap_rst),
    .d(pad_in),
    .q(pad_sync)
  );

  // ==========================================================================
  // Test clock state
  typedef struct packed {
    scan_tap_pkg::tap_state_e st;
    logic [scan_tap_pkg::IR_LEN-1:0] ir_shift;
    logic [scan_tap_pkg::IR_LEN-1:0] instruction_reg;
    logic [scan_tap_pkg::BYP_LEN-1:0] bypass_reg;
    logic [scan_tap_pkg::ID_LEN-1:0] identification_reg;
    logic [scan_tap_pkg::BSR_LEN-1:0] boundary_chain;
    logic dq_float;
  } tap_s;

  typedef struct packed {
    logic tdo;
    logic oe;
  } edge_s;

  tap_s t_reg;
  tap_s t_next;
  edge_s e_reg;
  edge_s e_next;
  logic shifting;
  logic serial_out;

  // Controller, instruction and data paths
  always_comb begin
    t_next = t_reg;
    t_next.st = tap_step(t_reg.st, tms); // R15
    case (t_reg.st)
      scan_tap_pkg::ST_RESET: begin
        t_next.instruction_reg = scan_tap_pkg::IR_RESET_VAL; // R1
      end
      scan_tap_pkg::ST_CAP_IR: begin
        t_next.ir_shift = scan_tap_pkg::IR_CAPTURE_VAL;
      end
      scan_tap_pkg::ST_SHIFT_IR: begin
        t_next.ir_shift = {tdi, t_reg.ir_shift[scan_tap_pkg::IR_LEN-1:1]}; // R11
      end
      scan_tap_pkg::ST_UPD_IR: begin
        t_next.instruction_reg = t_reg.ir_shift; // R4
        if (t_reg.ir_shift == scan_tap_pkg::INSTR_BYPASS) begin
          t_next.bypass_reg = '0; // R9
        end
      end
      scan_tap_pkg::ST_CAP_DR: begin
        if (t_reg.instruction_reg == scan_tap_pkg::INSTR_IDCODE) begin
          t_next.identification_reg = ID_VALUE; // R12
        end else if (uses_chain(t_reg.instruction_reg)) begin
          // Pad levels and the float flag enter the chain, never array contents
          t_next.boundary_chain = pad_sync; // R2 R3 R14
          t_next.boundary_chain[scan_tap_pkg::BSR_INTERNAL_IDX] = t_reg.dq_float; // R14
        end else begin
          t_next.bypass_reg = scan_tap_pkg::BYP_CAPTURE_VAL;
        end
      end
      scan_tap_pkg::ST_SHIFT_DR: begin
        if (t_reg.instruction_reg == scan_tap_pkg::INSTR_IDCODE) begin
          t_next.identification_reg = {tdi, t_reg.identification_reg[31:1]}; // R8
        end else if (uses_chain(t_reg.instruction_reg)) begin
          t_next.boundary_chain = {tdi, t_reg.boundary_chain[scan_tap_pkg::BSR_LEN-1:1]}; // R14
        end else begin
          // Reserved codes fall back to the bypass path
          t_next.bypass_reg = tdi; // R9
        end
      end
      default: begin
      end
    endcase
    // Both float instructions release the data outputs
    t_next.dq_float = (t_next.instruction_reg == scan_tap_pkg::INSTR_EXTEST) || // R5
                      (t_next.instruction_reg == scan_tap_pkg::INSTR_SAMPLE_Z); // R6 R7
  end

  always_ff @(posedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      t_reg <= '{st: scan_tap_pkg::ST_RESET, ir_shift: '0, // R1
                 instruction_reg: scan_tap_pkg::IR_RESET_VAL, bypass_reg: '0,
                 identification_reg: '0, boundary_chain: '0, dq_float: 1'b0};
    end else begin
      t_reg <= t_next;
    end
  end

  // ==========================================================================
  // Serial output on the falling edge
  always_comb begin
    shifting = (t_reg.st == scan_tap_pkg::ST_SHIFT_DR) || (t_reg.st == scan_tap_pkg::ST_SHIFT_IR);
    if (t_reg.st == scan_tap_pkg::ST_SHIFT_IR) begin
      serial_out = t_reg.ir_shift[0];
    end else if (t_reg.instruction_reg == scan_tap_pkg::INSTR_IDCODE) begin
      serial_out = t_reg.identification_reg[0];
    end else if (uses_chain(t_reg.instruction_reg)) begin
      serial_out = t_reg.boundary_chain[0];
    end else begin
      serial_out = t_reg.bypass_reg[0];
    end
    e_next.tdo = shifting ? serial_out : e_reg.tdo;
    e_next.oe = shifting; // R15
  end

  // Falling edge keeps half a period of hold for the tester
  always_ff @(negedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      e_reg <= '{tdo: 1'b0, oe: 1'b0};
    end else begin
      e_reg <= e_next; // R15
    end
  end

  assign tdo = e_reg.tdo;
  assign tdo_oe = e_reg.oe;
  assign active_instr = t_reg.instruction_reg;

  // ==========================================================================
  // Float request into the core clock
  sync_stage #(.WIDTH(1), .RESET_VAL(1'b0)) u_float_sync (
    .clk(core_clk),
    .rst(rst),
    .d(t_reg.dq_float),
    .q(float_core)
  );

  assign dq_hiz = float_core; // R5 R6

  // ==========================================================================
  // Checks
  property p_tms_reset; // R1
    @(posedge tck) disable iff (tap_rst) tms [*5] |=> (t_reg.st == scan_tap_pkg::ST_RESET);
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("five tms highs missed reset"); // R1

  property p_ir_load; // R4
    @(posedge tck) disable iff (tap_rst)
      (t_reg.st == scan_tap_pkg::ST_UPD_IR) |=> (t_reg.instruction_reg == $past(t_reg.ir_shift));
  endproperty
  a_ir_load: assert property (p_ir_load) else $error("instruction not loaded on update"); // R4

  property p_float; // R5
    @(posedge tck) disable iff (tap_rst)
      ((t_reg.instruction_reg == scan_tap_pkg::INSTR_EXTEST) ||
       (t_reg.instruction_reg == scan_tap_pkg::INSTR_SAMPLE_Z)) |-> t_reg.dq_float;
  endproperty
  a_float: assert property (p_float) else $error("float instruction without float"); // R5

  property p_float_core; // R6
    @(posedge core_clk) disable iff (rst) t_reg.dq_float [*3] |=> dq_hiz;
  endproperty
  a_float_core: assert property (p_float_core) else $error("float not seen in core domain"); // R6

  property p_sample_drives; // R7
    @(posedge tck) disable iff (tap_rst)
      (t_reg.instruction_reg == scan_tap_pkg::INSTR_SAMPLE) |-> !t_reg.dq_float;
  endproperty
  a_sample_drives: assert property (p_sample_drives) else $error("sample floated outputs"); // R7

  property p_id_shift; // R8
    @(posedge tck) disable iff (tap_rst)
      ((t_reg.st == scan_tap_pkg::ST_SHIFT_DR) &&
       (t_reg.instruction_reg == scan_tap_pkg::INSTR_IDCODE))
      |=> (t_reg.identification_reg[31] == $past(tdi)) &&
          (t_reg.identification_reg[30:0] == $past(t_reg.identification_reg[31:1]));
  endproperty
  a_id_shift: assert property (p_id_shift) else $error("identity path did not shift tdi"); // R8

  property p_bypass_clear; // R9
    @(posedge tck) disable iff (tap_rst)
      ((t_reg.st == scan_tap_pkg::ST_UPD_IR) && (t_reg.ir_shift == scan_tap_pkg::INSTR_BYPASS))
      |=> (t_reg.bypass_reg == 1'b0);
  endproperty
  a_bypass_clear: assert property (p_bypass_clear) else $error("bypass bit not cleared"); // R9

  property p_ir_len; // R11
    @(posedge tck) disable iff (tap_rst)
      (t_reg.st == scan_tap_pkg::ST_SHIFT_IR) ##1 (t_reg.st == scan_tap_pkg::ST_SHIFT_IR)
      ##1 (t_reg.st == scan_tap_pkg::ST_SHIFT_IR)
      |=> (t_reg.ir_shift == {$past(tdi), $past(tdi, 2), $past(tdi, 3)});
  endproperty
  a_ir_len: assert property (p_ir_len) else $error("instruction path not three bits"); // R11

  property p_id_capture; // R12
    @(posedge tck) disable iff (tap_rst)
      ((t_reg.st == scan_tap_pkg::ST_CAP_DR) &&
       (t_reg.instruction_reg == scan_tap_pkg::INSTR_IDCODE))
      |=> (t_reg.identification_reg == ID_VALUE) && t_reg.identification_reg[0];
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("identity capture wrong"); // R12

  property p_internal_cell; // R14
    @(posedge tck) disable iff (tap_rst)
      ((t_reg.st == scan_tap_pkg::ST_CAP_DR) && uses_chain(t_reg.instruction_reg))
      |=> (t_reg.boundary_chain[scan_tap_pkg::BSR_INTERNAL_IDX] == $past(t_reg.dq_float)) &&
          (t_reg.boundary_chain[0] == $past(pad_sync[0]));
  endproperty
  a_internal_cell: assert property (p_internal_cell) else $error("boundary capture wrong"); // R14

  // Enable trails the shift state by one falling edge
  property p_tdo_oe; // R15
    @(negedge tck) disable iff (tap_rst) 1'b1 |=> (tdo_oe == $past(shifting));
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("tdo enable not tied to shifting"); // R15

  // Any pass through the reset state reloads identification
  property p_reset_instr; // R1
    @(posedge tck) disable iff (tap_rst)
      (t_reg.st == scan_tap_pkg::ST_RESET) |=> (active_instr == scan_tap_pkg::INSTR_IDCODE);
  endproperty
  a_reset_instr: assert property (p_reset_instr) else $error("reset state kept old code"); // R1

  // Bypass keeps exactly the last bit taken from tdi
  property p_bypass_shift; // R9
    @(posedge tck) disable iff (tap_rst)
      ((t_reg.st == scan_tap_pkg::ST_SHIFT_DR) &&
       (t_reg.instruction_reg == scan_tap_pkg::INSTR_BYPASS))
      |=> (t_reg.bypass_reg[0] == $past(tdi));
  endproperty
  a_bypass_shift: assert property (p_bypass_shift) else $error("bypass bit lost tdi"); // R9

endmodule : scan_tap

`default_nettype wire

// >>> testbench/jtag_tester.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Test controller model; its clock runs only inside frames
module jtag_tester (
  output var logic tck, // Test clock, still between frames
  output var logic tms, // Mode select
  output var logic tdi, // Serial data to the device
  input wire logic tdo, // Serial data from the device
  input wire logic tdo_oe // High while the device drives tdo
);
  logic held; // Last driven level of the data wire
  logic tdo_line; // Level seen on the wire

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    held = 1'b0;
  end

  // No pull on the wire: released, it shows the inverse of its last level
  always @(tdo or tdo_oe) begin
    if (tdo_oe) begin
      held = tdo;
    end
  end
  assign tdo_line = tdo_oe ? tdo : ~held;

  // One 48 ns period; inputs move just after the falling edge
  task automatic pulse(input logic m, input logic d, output logic q, output logic oe);
    #1;
    tms = m;
    tdi = d;
    #23;
    q = tdo_line;
    oe = tdo_oe;
    tck = 1'b1;
    #24;
    tck = 1'b0;
  endtask : pulse

  // Walk through the state diagram back to idle
  task automatic tap_reset(input int k);
    logic q;
    logic oe;
    repeat (k) pulse(1'b1, 1'b0, q, oe);
    pulse(1'b0, 1'b0, q, oe);
  endtask : tap_reset

  // Full scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [159:0] din,
      output logic [159:0] dout, output logic all_oe);
    logic q;
    logic oe;
    dout = '0;
    all_oe = 1'b1;
    // Two idle periods let the pad flops follow a pad change
    pulse(1'b0, 1'b0, q, oe);
    pulse(1'b0, 1'b0, q, oe);
    pulse(1'b1, 1'b0, q, oe);
    if (ir) begin
      pulse(1'b1, 1'b0, q, oe);
    end
    pulse(1'b0, 1'b0, q, oe);
    pulse(1'b0, 1'b0, q, oe);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q, oe);
      dout[i] = q;
      all_oe = all_oe & oe;
    end
    pulse(1'b1, 1'b0, q, oe);
    pulse(1'b0, 1'b0, q, oe);
  endtask : scan
endmodule : jtag_tester

`default_nettype wire

// >>> testbench/test_boundary_scan_tap.sv
`timescale 1ns/1ps
`default_nettype none

module test_boundary_scan_tap;
  typedef struct {
    logic [2:0] code;
    logic hiz;
    int len;
    logic [159:0] cap;
  } row_s;

  // ==========================================================================
  // Signals and instances
  logic core_clk, rst, tck, tms, tdi, tdo, tdo_oe, dq_hiz;
  logic [scan_tap_pkg::BSR_LEN-1:0] pad_in;
  logic [2:0] active_instr;
  logic [scan_tap_pkg::BSR_LEN-1:0] pads;
  logic [159:0] pat;
  logic [31:0] id_exp;
  logic [16:0] cfg;
  row_s rows[5];
  int err_count;
  int checked;

  scan_tap i_dut (.core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .dq_hiz(dq_hiz),
    .active_instr(active_instr));
  jtag_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  // Core clock, 5 ns
  always #2.5 core_clk = ~core_clk;

  // ==========================================================================
  // Compare, expectation and scan helpers
  task automatic check_scan(input logic [159:0] got, input logic [159:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: scan out %h wanted %h", $time, got, exp);
    end
  endtask : check_scan

  task automatic check_code(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: instruction %b wanted %b", $time, got, exp);
    end
  endtask : check_code

  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: flag %b wanted %b", $time, got, exp);
    end
  endtask : check_bit

  // Captured bits come out first, then what went in at tdi
  function automatic logic [159:0] exp_scan(input int len, input logic [159:0] cap,
      input logic [159:0] din, input int n);
    logic [159:0] e;
    e = '0;
    for (int i = 0; i < n; i++) begin
      e[i] = (i < len) ? cap[i] : din[i - len];
    end
    return e;
  endfunction : exp_scan

  // Internal cell carries the float flag, pads elsewhere
  function automatic logic [159:0] bcap(input logic hiz, input logic [106:0] p);
    logic [159:0] c;
    c = 160'(p);
    c[scan_tap_pkg::BSR_INTERNAL_IDX] = hiz;
    return c;
  endfunction : bcap

  task automatic run_scan(input logic ir, input int len, input logic [159:0] cap,
      input logic [159:0] din, input int n);
    logic [159:0] q;
    logic oe;
    i_tester.scan(ir, n, din, q, oe);
    #1;
    check_scan(q, exp_scan(len, cap, din, n));
    check_bit(oe, 1'b1);
    check_bit(tdo_oe, 1'b0);
  endtask : run_scan

  task automatic load(input logic [2:0] code);
    run_scan(1'b1, 3, 160'(scan_tap_pkg::IR_CAPTURE_VAL), {154'h0, code, 3'h6}, 6);
    check_code(active_instr, code);
    repeat (4) @(posedge core_clk);
    #1;
  endtask : load

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Watchdog, far above the expected run of about 40 us
  initial begin
    #200_000;
    err_count++;
    $display("unexpected at %0t: watchdog ran out", $time);
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b0;
    err_count = 0;
    checked = 0;
    pads = 107'h3a5_1234_5678_9abc_def0_0fed_cba9;
    pad_in = pads;
    pat = {5{32'hc3a5_96f1}};
    cfg = '0;
    cfg[14:12] = scan_tap_pkg::ID_DENS_DEFAULT;
    cfg[10:9] = scan_tap_pkg::ID_WIDTH_DEFAULT;
    cfg[5] = 1'b1;
    cfg[1] = 1'b1;
    id_exp = {scan_tap_pkg::ID_REV_DEFAULT, cfg, scan_tap_pkg::ID_MFR_DEFAULT, 1'b1};
    // Reserved codes are never loaded by the tester
    rows[0] = '{scan_tap_pkg::INSTR_IDCODE, 1'b0, 32, 160'(id_exp)};
    rows[1] = '{scan_tap_pkg::INSTR_BYPASS, 1'b0, 1, 160'h0};
    rows[2] = '{scan_tap_pkg::INSTR_SAMPLE, 1'b0, 107, bcap(1'b0, pads)};
    rows[3] = '{scan_tap_pkg::INSTR_EXTEST, 1'b1, 107, bcap(1'b1, pads)};
    rows[4] = '{scan_tap_pkg::INSTR_SAMPLE_Z, 1'b1, 107, bcap(1'b1, pads)};
    // Clean reset edge after time zero; tck is still, so the edge must reset
    @(posedge core_clk);
    #1;
    rst = 1'b1;
    // Reset for 16 core cycles, values seen during reset
    repeat (16) @(posedge core_clk);
    #1;
    check_code(active_instr, scan_tap_pkg::INSTR_IDCODE);
    check_bit(tdo_oe, 1'b0);
    check_bit(dq_hiz, 1'b0);
    rst = 1'b0;
    i_tester.tap_reset(8);
    $display("test reset done");
    // Table of instructions, each loaded then scanned
    foreach (rows[r]) begin
      load(rows[r].code);
      check_bit(dq_hiz, rows[r].hiz);
      run_scan(1'b0, rows[r].len, rows[r].cap, pat, rows[r].len + 24);
      $display("test row %0d done", r);
    end
    // Second reset in mid run while outputs are floated
    @(posedge core_clk);
    #1;
    rst = 1'b1;
    i_tester.tap_reset(2);
    check_code(active_instr, scan_tap_pkg::INSTR_IDCODE);
    check_bit(dq_hiz, 1'b0);
    @(posedge core_clk);
    #1;
    rst = 1'b0;
    i_tester.tap_reset(5);
    run_scan(1'b0, 32, 160'(id_exp), pat, 40);
    $display("test mid reset done");
    // Pads change between samples and must be seen
    @(posedge core_clk);
    #1;
    pad_in = ~pads;
    load(scan_tap_pkg::INSTR_SAMPLE);
    run_scan(1'b0, 107, bcap(1'b0, ~pads), pat, 110);
    $display("test pad change done");
    // Five mode-select highs return to identification
    load(scan_tap_pkg::INSTR_BYPASS);
    i_tester.tap_reset(5);
    #1;
    check_code(active_instr, scan_tap_pkg::INSTR_IDCODE);
    run_scan(1'b0, 32, 160'(id_exp), pat, 33);
    $display("test tms reset done");
    report_and_stop();
  end
endmodule : test_boundary_scan_tap

`default_nettype wire
